// ---- hwlos_map.svh ----
// Register offsets, field positions, reset values and timing counts
// for the hardware-logic output stage; included by bare name.
`ifndef HWLOS_MAP_SVH
`define HWLOS_MAP_SVH

// APB byte addresses
`define HWLOS_A_FEN        12'h000
`define HWLOS_A_FVAL       12'h004
`define HWLOS_A_MON        12'h008
`define HWLOS_A_CTRL       12'h00c
`define HWLOS_A_GMODE      12'h010
`define HWLOS_A_CHCFG      12'h040
`define HWLOS_A_GLINK      12'h080
`define HWLOS_A_CLINK      12'h0c0

// Field positions
`define HWLOS_CTRL_ENC     0
`define HWLOS_CFG_POL      0
`define HWLOS_CFG_STEP     1
`define HWLOS_CFG_UNIT     8
`define HWLOS_CFG_FMODE    11
`define HWLOS_CFG_W        13
`define HWLOS_GL_SEL       31
`define HWLOS_GL_W         30
`define HWLOS_CL_W         22
`define HWLOS_ENC_CH0      8
`define HWLOS_ENC_CH1      9

// Reset values and the step clamp limit
`define HWLOS_RST_WORD     14'h0000
`define HWLOS_RST_CFG      13'h0000
`define HWLOS_RST_GMODE    28'h0000000
`define HWLOS_STEP_MAX     7'h40

// Timing: clock period and delay units in picoseconds
`define HWLOS_CLK_PS       100000
`define HWLOS_T_12N5_PS    12500
`define HWLOS_T_25N_PS     25000
`define HWLOS_T_50N_PS     50000
`define HWLOS_T_100N_PS    100000
`define HWLOS_T_1U_PS      1000000
`define HWLOS_T_10U_PS     10000000
`define HWLOS_T_100U_PS    100000000
`define HWLOS_T_1M_PS      1000000000
`define HWLOS_CYC(t)       (((t) + `HWLOS_CLK_PS - 1) / `HWLOS_CLK_PS)

`endif

// ---- hwlos_pkg.sv ----
// Types shared by the output stage modules.
// Field layout of hwlos_cfg_s matches the channel config register.
package hwlos_pkg;
    typedef enum logic [1:0] {hwlos_g_and, hwlos_g_or, hwlos_g_xor} hwlos_gmode_e;
    typedef enum logic [1:0] {hwlos_f_off, hwlos_f_on, hwlos_f_hold} hwlos_fmode_e;
    typedef struct packed {
        hwlos_fmode_e fmode;
        logic [2:0]   unit;
        logic [6:0]   step;
        logic         pol;
    } hwlos_cfg_s;
endpackage : hwlos_pkg

// ---- hwlos_cfg_if.sv ----
// Carries one channel's configuration from the register file to the channel.
// Assumes hwlos_pkg is compiled first.
`timescale 1ns/1ns
interface hwlos_cfg_if;
    import hwlos_pkg::*;
    hwlos_cfg_s cfg;
    modport src (output cfg);
    modport dst (input cfg);
endinterface : hwlos_cfg_if

// ---- hwlos_gate.sv ----
// One combining gate over a masked input vector.
// Assumes the caller has already chosen the feedback or host source.
`timescale 1ns/1ns
module hwlos_gate #(
    parameter int W = 30
) (
    input  wire logic [W-1:0]            bits,
    input  wire logic [W-1:0]            mask,
    input  wire hwlos_pkg::hwlos_gmode_e mode,
    output logic                         y
);
    import hwlos_pkg::*;

    always_comb begin
        case (mode)
            hwlos_g_or:  y = |(bits & mask);
            hwlos_g_xor: y = ^(bits & mask);
            // An AND with nothing linked reads low, not high
            default:     y = (|mask) & (&(bits | ~mask));
        endcase
    end
endmodule : hwlos_gate

// ---- hwlos_chan.sv ----
// One output channel: polarity, step delay, fault policy, force override.
// Assumes tick is a one-cycle enable per delay unit on pclk.
`timescale 1ns/1ns
module hwlos_chan (
    input  wire logic  pclk,
    input  wire logic  presetn,
    hwlos_cfg_if.dst   cfg,
    input  wire logic  din,
    input  wire logic [7:0] tick,
    input  wire logic  force_en,
    input  wire logic  force_val,
    input  wire logic  fault,
    output logic       q
);
    import hwlos_pkg::*;

    logic [63:0] sr_q;
    logic        pol_in;
    logic        dly;
    logic        q_q;

    assign pol_in = din ^ cfg.cfg.pol;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= 64'h0;
        end else if (tick[cfg.cfg.unit]) begin
            sr_q <= {sr_q[62:0], pol_in};
        end
    end

    assign dly = (cfg.cfg.step == 7'h00) ? pol_in : sr_q[6'(cfg.cfg.step - 7'h01)];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_q <= 1'b0;
        end else if (fault) begin
            case (cfg.cfg.fmode)
                hwlos_f_on:   q_q <= 1'b1;
                hwlos_f_hold: q_q <= q_q;
                default:      q_q <= 1'b0;
            endcase
        end else if (force_en) begin
            q_q <= force_val;
        end else begin
            q_q <= dly;
        end
    end
    assign q = q_q;

    a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
        fault && cfg.cfg.fmode == hwlos_f_off |=> !q) else $error("fault off not low");
    a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
        fault && cfg.cfg.fmode == hwlos_f_hold |=> $stable(q)) else $error("hold lost");
    a_force_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !fault && force_en |=> q == $past(force_val)) else $error("force ignored");
    a_zero_step: assert property (@(posedge pclk) disable iff (!presetn)
        !fault && !force_en && cfg.cfg.step == 7'h00 |=> q == $past(pol_in))
        else $error("undelayed path wrong");
endmodule : hwlos_chan

// ---- hwlos_top.sv ----
// Output stage: 14 combining gates, 8 DC and 6 differential channels,
// APB register file. Assumes counter outputs, host bits, encoder clock
// and fault inputs come from logic on pclk; ext_in comes from pins.
//
// Summary of operation
// - Fourteen gates, each AND, OR or XOR of linked bits, AND default.
// - Gate takes external bits plus either channel feedback or host bits.
// - Eight DC and six differential channels, each driving one terminal.
// - Channel input is the OR of linked counter and gate bits.
// - Polarity bit passes or complements the combined input.
// - Delay is 0 to 64 steps of a unit; zero means no delay.
// - Units 12.5ns, 25ns, 50ns, 0.1us, 1us, 10us, 100us, 1ms; the 12.5ns, 25ns and 50ns units each run as one 100ns pclk.
// - Realised delay may err by one unit; small units are better.
// - On host error or logic stop drive low, high or hold.
// - Fault level goes to the terminal ignoring polarity.
// - Force-enable bit makes the channel drive its force-value bit.
// - Monitor word shows each terminal's present state.
// - Bits 0-7 DC, 8-13 differential, 14 and 15 zero.
// - Differential channels 0 and 1 carry the encoder clock.
// - Encoder-tied channels keep default settings, unchangeable.
// - Encoder clock passes unaltered so its idle monoflop gap survives.
`timescale 1ns/1ns
`include "hwlos_map.svh"
module hwlos_top #(
    parameter int UNIT_1MS_CYC = `HWLOS_CYC(`HWLOS_T_1M_PS)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] ext_in,
    input  wire logic [13:0] host_y,
    input  wire logic [7:0]  counter_out,
    input  wire logic        enc_clk,
    input  wire logic        host_error,
    input  wire logic        logic_stop,
    output logic      [7:0]  out_dc,
    output logic      [5:0]  out_diff
);
    import hwlos_pkg::*;

    localparam int NCH = 14;
    localparam int NG  = 14;

    // unit lengths in cycles, rounded up
    localparam int UNIT_CYC [8] = '{
        `HWLOS_CYC(`HWLOS_T_12N5_PS),
        `HWLOS_CYC(`HWLOS_T_25N_PS),
        `HWLOS_CYC(`HWLOS_T_50N_PS),
        `HWLOS_CYC(`HWLOS_T_100N_PS),
        `HWLOS_CYC(`HWLOS_T_1U_PS),
        `HWLOS_CYC(`HWLOS_T_10U_PS),
        `HWLOS_CYC(`HWLOS_T_100U_PS),
        UNIT_1MS_CYC
    };

    logic [15:0]                 ext_s1_q;
    logic [15:0]                 ext_s2_q;
    logic [13:0]                 fen_q;
    logic [13:0]                 fval_q;
    logic [27:0]                 gmode_q;
    logic                        enc_en_q;
    logic                        fault_q;
    hwlos_cfg_s                  chcfg_q [NCH];
    logic [31:0]                 glink_q [NG];
    logic [`HWLOS_CL_W-1:0]      clink_q [NCH];
    logic [31:0]                 prdata_q;
    logic                        pready_q;
    logic                        pslverr_q;
    logic [31:0]                 rd_d;
    logic                        setup;
    logic                        wr_acc;
    logic [3:0]                  idx;
    logic [7:0]                  tick;
    logic [NG-1:0]               gate_y;
    logic [NCH-1:0]              chan_q;
    logic [NCH-1:0]              din;
    hwlos_cfg_s                  wcfg;

    // Decode helpers shared by the read and write paths
    function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
        return (a[11:6] == base[11:6]) && (a[5:2] < 4'hE) && (a[1:0] == 2'b00);
    endfunction : in_bank

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `HWLOS_A_FEN) || (a == `HWLOS_A_FVAL) || (a == `HWLOS_A_MON)
            || (a == `HWLOS_A_CTRL) || (a == `HWLOS_A_GMODE)
            || in_bank(a, `HWLOS_A_CHCFG) || in_bank(a, `HWLOS_A_GLINK)
            || in_bank(a, `HWLOS_A_CLINK);
    endfunction : is_mapped

    function automatic logic is_enc_ch(input int c);
        return (c == `HWLOS_ENC_CH0) || (c == `HWLOS_ENC_CH1);
    endfunction : is_enc_ch

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign idx    = paddr[5:2];

    // Pin inputs pass two flops before any gate sees them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q <= 16'h0000;
            ext_s2_q <= 16'h0000;
        end else begin
            ext_s1_q <= ext_in;
            ext_s2_q <= ext_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= host_error | logic_stop;
        end
    end

    // Zero-wait slave: pready rises in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !is_mapped(paddr);
            if (setup && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fen_q    <= `HWLOS_RST_WORD;
            fval_q   <= `HWLOS_RST_WORD;
            gmode_q  <= `HWLOS_RST_GMODE;
            enc_en_q <= 1'b0;
        end else if (wr_acc) begin
            case (paddr)
                `HWLOS_A_FEN:   fen_q    <= pwdata[13:0];
                `HWLOS_A_FVAL:  fval_q   <= pwdata[13:0];
                `HWLOS_A_GMODE: gmode_q  <= pwdata[27:0];
                `HWLOS_A_CTRL:  enc_en_q <= pwdata[`HWLOS_CTRL_ENC];
                default: ;
            endcase
        end
    end

    // step clamped to its top value on write
    always_comb begin
        wcfg = hwlos_cfg_s'(pwdata[`HWLOS_CFG_W-1:0]);
        if (wcfg.step > `HWLOS_STEP_MAX) begin
            wcfg.step = `HWLOS_STEP_MAX;
        end
    end

    // Per-channel and per-gate link and config registers
    for (genvar c = 0; c < NCH; c++) begin : g_cfg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chcfg_q[c] <= hwlos_cfg_s'(`HWLOS_RST_CFG);
            end else if (enc_en_q && is_enc_ch(c)) begin
                chcfg_q[c] <= hwlos_cfg_s'(`HWLOS_RST_CFG);
            end else if (wr_acc && in_bank(paddr, `HWLOS_A_CHCFG) && idx == 4'(c)) begin
                chcfg_q[c] <= wcfg;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                clink_q[c] <= '0;
            end else if (wr_acc && in_bank(paddr, `HWLOS_A_CLINK) && idx == 4'(c)) begin
                clink_q[c] <= pwdata[`HWLOS_CL_W-1:0];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                glink_q[c] <= 32'h00000000;
            end else if (wr_acc && in_bank(paddr, `HWLOS_A_GLINK) && idx == 4'(c)) begin
                glink_q[c] <= pwdata;
            end
        end
    end

    // read mux; unused upper bits read zero, except GLINK bit 30, which reads back as written
    always_comb begin
        rd_d = 32'h00000000;
        if (paddr == `HWLOS_A_FEN) begin
            rd_d[13:0] = fen_q;
        end else if (paddr == `HWLOS_A_FVAL) begin
            rd_d[13:0] = fval_q;
        end else if (paddr == `HWLOS_A_MON) begin
            rd_d[13:0] = chan_q;
        end else if (paddr == `HWLOS_A_CTRL) begin
            rd_d[`HWLOS_CTRL_ENC] = enc_en_q;
        end else if (paddr == `HWLOS_A_GMODE) begin
            rd_d[27:0] = gmode_q;
        end else if (in_bank(paddr, `HWLOS_A_CHCFG)) begin
            rd_d[`HWLOS_CFG_W-1:0] = chcfg_q[idx];
        end else if (in_bank(paddr, `HWLOS_A_GLINK)) begin
            rd_d = glink_q[idx];
        end else if (in_bank(paddr, `HWLOS_A_CLINK)) begin
            rd_d[`HWLOS_CL_W-1:0] = clink_q[idx];
        end
    end

    // one divider per unit; short units tick every cycle
    for (genvar u = 0; u < 8; u++) begin : g_unit
        logic [13:0] cnt_q;
        logic        t_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q <= 14'h0000;
                t_q   <= 1'b0;
            end else if (cnt_q == 14'(UNIT_CYC[u] - 1)) begin
                cnt_q <= 14'h0000;
                t_q   <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 14'h0001;
                t_q   <= 1'b0;
            end
        end
        assign tick[u] = t_q;
    end

    // gates see external bits plus one other source
    for (genvar g = 0; g < NG; g++) begin : g_gate
        logic [`HWLOS_GL_W-1:0] bits;
        assign bits = {glink_q[g][`HWLOS_GL_SEL] ? host_y : chan_q, ext_s2_q};
        hwlos_gate #(
            .W    (`HWLOS_GL_W)
        ) u_gate (
            .bits (bits),
            .mask (glink_q[g][`HWLOS_GL_W-1:0]),
            .mode (hwlos_gmode_e'(gmode_q[2*g +: 2])),
            .y    (gate_y[g])
        );
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        hwlos_cfg_if u_cfg ();
        assign u_cfg.cfg = chcfg_q[c];
        if (is_enc_ch(c)) begin : g_enc
            // encoder clock replaces the linked sources untouched
            assign din[c] = enc_en_q ? enc_clk
                : (|(counter_out & clink_q[c][7:0])) | (|(gate_y & clink_q[c][21:8]));
        end else begin : g_norm
            assign din[c] = (|(counter_out & clink_q[c][7:0]))
                | (|(gate_y & clink_q[c][21:8]));
        end
        hwlos_chan u_chan (
            .pclk      (pclk),
            .presetn   (presetn),
            .cfg       (u_cfg.dst),
            .din       (din[c]),
            .tick      (tick),
            .force_en  (fen_q[c]),
            .force_val (fval_q[c]),
            .fault     (fault_q),
            .q         (chan_q[c])
        );
    end

    assign out_dc   = chan_q[7:0];
    assign out_diff = chan_q[13:8];
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_setup_ready: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready ##1 !pready) else $error("pready not one access cycle");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup and !is_mapped(paddr) |=> s_access and pslverr)
        else $error("unmapped address not flagged");

    a_monitor_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup and paddr == `HWLOS_A_MON and !pwrite
        |=> prdata == {18'h0, $past(chan_q)}) else $error("monitor word wrong");

    // Pinned config lands a cycle after enable, so skip that cycle
    a_enc_follow: assert property (@(posedge pclk) disable iff (!presetn)
        enc_en_q ##1 enc_en_q && !fault_q && !fen_q[`HWLOS_ENC_CH0]
        |=> out_diff[0] == $past(enc_clk)) else $error("encoder clock not passed");

    // first tied channel pinned as well
    a_enc_cfg_ch0: assert property (@(posedge pclk) disable iff (!presetn)
        enc_en_q ##1 enc_en_q |-> chcfg_q[`HWLOS_ENC_CH0] == hwlos_cfg_s'(`HWLOS_RST_CFG))
        else $error("tied channel config changed");

    a_enc_cfg_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        enc_en_q ##1 enc_en_q |-> chcfg_q[`HWLOS_ENC_CH1] == hwlos_cfg_s'(`HWLOS_RST_CFG))
        else $error("tied channel config changed");

    a_force_reach: assert property (@(posedge pclk) disable iff (!presetn)
        !fault_q && fen_q[13] ##1 !fault_q && fen_q[13] |-> out_diff[5] == $past(fval_q[13]))
        else $error("bit 13 not on differential 5");

    // bits above the channel map read zero
    a_word_upper: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite
        && (paddr == `HWLOS_A_FEN || paddr == `HWLOS_A_FVAL || paddr == `HWLOS_A_MON)
        |=> prdata[31:14] == 18'h0) else $error("upper word bits not zero");

    // fixed high reaches the terminal whatever the polarity
    a_fault_dc0: assert property (@(posedge pclk) disable iff (!presetn)
        fault_q && chcfg_q[0].fmode == hwlos_f_on |=> out_dc[0])
        else $error("fault on level not high");

    // force-enable write lands at the access edge
    a_fen_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `HWLOS_A_FEN |=> {18'h0, fen_q} == ($past(pwdata) & 32'h00003fff))
        else $error("force-enable write lost");

    // either fault source raises the policy one cycle later
    a_fault_src: assert property (@(posedge pclk) disable iff (!presetn)
        host_error || logic_stop |=> fault_q)
        else $error("fault source not registered");
endmodule : hwlos_top

// ---- hwlos_field.sv ----
// Field devices on the output connector: input sensors and a clock watcher.
// Assumes the sensor levels settle well inside one pclk period.
`timescale 1ns/1ns
module hwlos_field (
    input  wire logic        pclk,
    input  wire logic [15:0] pin_drive,
    input  wire logic [5:0]  out_diff,
    output logic      [15:0] ext_in,
    output int               enc_edges
);
    logic prev_q;
    // Push-pull sensors, so the pins never float
    assign ext_in = pin_drive;
    initial begin
        enc_edges = 0;
        prev_q = 1'b0;
    end
    always @(posedge pclk) begin
        if (out_diff[0] !== prev_q) begin
            enc_edges <= enc_edges + 1;
        end
        prev_q <= out_diff[0];
    end
endmodule : hwlos_field

// ---- tb.sv ----
// Self-checking bench for the output stage, driven over APB.
// Assumes the register map header and hwlos_pkg are compiled first.
`timescale 1ns/1ns
`include "hwlos_map.svh"
module tb;
    localparam int UNIT_MS = 20;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] ext_in;
    logic [15:0] pin_drive;
    logic [13:0] host_y;
    logic [7:0]  counter_out;
    logic        enc_clk;
    logic        host_error;
    logic        logic_stop;
    logic [7:0]  out_dc;
    logic [5:0]  out_diff;
    logic [13:0] outs;
    int          enc_edges;
    int          err_count;
    int          checks_done;
    int          ucyc [8] = '{1, 1, 1, 1, 10, 100, 1000, UNIT_MS};
    logic [11:0] defs [8] = '{`HWLOS_A_FEN, `HWLOS_A_FVAL, `HWLOS_A_MON, `HWLOS_A_CTRL,
                              `HWLOS_A_GMODE, `HWLOS_A_CHCFG, `HWLOS_A_GLINK, `HWLOS_A_CLINK};
    logic [31:0] d;
    logic        e;
    int          c0;

    assign outs = {out_diff, out_dc};

    hwlos_top #(.UNIT_1MS_CYC(UNIT_MS)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_in(ext_in), .host_y(host_y), .counter_out(counter_out),
        .enc_clk(enc_clk), .host_error(host_error), .logic_stop(logic_stop),
        .out_dc(out_dc), .out_diff(out_diff)
    );
    hwlos_field field (
        .pclk(pclk), .pin_drive(pin_drive), .out_diff(out_diff), .ext_in(ext_in),
        .enc_edges(enc_edges)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("TB counts: checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, wd, rd, err);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, xerr});
    endtask : rd_chk

    // Fixed settle; every untimed path is at most three cycles long
    task automatic look(input int idx, input logic v);
        repeat (6) @(posedge pclk);
        check({31'h0, outs[idx]}, {31'h0, v});
    endtask : look

    task automatic measure(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        counter_out[1] <= v;
        while (outs[2] !== v && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1);
        if (outs[2] !== v) begin
            err_count++;
            print_verdict();
        end
    endtask : measure

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pin_drive = 16'h0000;
        host_y = 14'h0000;
        counter_out = 8'h00;
        enc_clk = 1'b0;
        host_error = 1'b0;
        logic_stop = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk(defs[i], 32'h0, 1'b0);
        end
        rd_chk(12'hffc, 32'h0, 1'b1);
        $display("test defaults done");

        wr(`HWLOS_A_GLINK, 32'h80010001);
        wr(`HWLOS_A_CLINK + 12'h004, 32'h00000100);
        for (int m = 0; m < 3; m++) begin
            wr(`HWLOS_A_GMODE, m);
            for (int p = 0; p < 4; p++) begin
                pin_drive <= {15'h0, p[0]};
                host_y <= {13'h0, p[1]};
                e = (m == 0) ? &p[1:0] : (m == 1) ? |p[1:0] : ^p[1:0];
                look(1, e);
            end
        end
        $display("test gates done");

        wr(`HWLOS_A_CLINK + 12'h008, 32'h00000002);
        for (int u = 0; u < 8; u++) begin
            wr(`HWLOS_A_CHCFG + 12'h008, (u << 8) | (2 << 1));
            measure(1'b1, ucyc[u], 3 * ucyc[u] + 3);
            measure(1'b0, ucyc[u], 3 * ucyc[u] + 3);
        end
        wr(`HWLOS_A_CHCFG + 12'h008, 32'h000000fe);
        rd_chk(`HWLOS_A_CHCFG + 12'h008, 32'h00000080, 1'b0);
        $display("test delay done");

        wr(`HWLOS_A_CLINK, 32'h00000001);
        wr(`HWLOS_A_CHCFG, 32'h00000001);
        look(0, 1'b1);
        host_error <= 1'b1;
        look(0, 1'b0);
        host_error <= 1'b0;
        look(0, 1'b1);
        wr(`HWLOS_A_CHCFG, 32'h00000801);
        counter_out[0] <= 1'b1;
        look(0, 1'b0);
        logic_stop <= 1'b1;
        look(0, 1'b1);
        logic_stop <= 1'b0;
        wr(`HWLOS_A_CHCFG, 32'h00001001);
        counter_out[0] <= 1'b0;
        look(0, 1'b1);
        host_error <= 1'b1;
        look(0, 1'b1);
        counter_out[0] <= 1'b1;
        look(0, 1'b1);
        host_error <= 1'b0;
        look(0, 1'b0);
        $display("test fault done");

        // Gate 1 ANDs channel 0 feedback, mode code 3
        wr(`HWLOS_A_GLINK + 12'h004, 32'h00010000);
        wr(`HWLOS_A_CLINK + 12'h00c, 32'h00000200);
        wr(`HWLOS_A_GMODE, 32'h0000000c);
        look(3, 1'b0);
        counter_out[0] <= 1'b0;
        look(3, 1'b1);
        counter_out[0] <= 1'b1;
        $display("test feedback done");

        wr(`HWLOS_A_FEN, 32'hffffffff);
        rd_chk(`HWLOS_A_FEN, 32'h00003fff, 1'b0);
        for (int k = 0; k < 2; k++) begin
            d = k ? 32'h0000d555 : 32'h00002aaa;
            wr(`HWLOS_A_FVAL, d);
            wr(`HWLOS_A_MON, 32'h0000ffff);
            repeat (6) @(posedge pclk);
            check({18'h0, outs}, d & 32'h3fff);
            rd_chk(`HWLOS_A_MON, d & 32'h3fff, 1'b0);
        end
        wr(`HWLOS_A_FEN, 32'h0);
        look(0, 1'b0);
        $display("test force done");

        wr(`HWLOS_A_CTRL, 32'h1);
        wr(`HWLOS_A_CHCFG + 12'h020, 32'h1);
        rd_chk(`HWLOS_A_CHCFG + 12'h020, 32'h0, 1'b0);
        c0 = enc_edges;
        for (int t = 0; t < 8; t++) begin
            enc_clk <= ~enc_clk;
            repeat (4) @(posedge pclk);
            check({31'h0, outs[9]}, {31'h0, enc_clk});
        end
        repeat (10) @(posedge pclk);
        check(enc_edges - c0, 32'd8);
        check({31'h0, outs[10]}, 32'h0);
        $display("test encoder done");
        print_verdict();
    end
endmodule : tb
